/* File: hw/llcps_pkg.sv */
package llcps_pkg;
	// Timebase and delays
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned PH1_MS = 15;
	localparam int unsigned PH2_MS = 30;
	localparam int unsigned PH3_MS = 40;
	localparam int unsigned EXT_PROT_US = 304;
	localparam int unsigned OC_CLEAR_US = 76;
	localparam int unsigned OLP_DELAY_MS = 38;
	localparam int unsigned RESTART_MS = 810;
	localparam int unsigned OC_OSC_LIMIT = 32;
	localparam int unsigned PH1_CYC = PH1_MS * (CLK_HZ / 1000);
	localparam int unsigned PH2_CYC = PH2_MS * (CLK_HZ / 1000);
	localparam int unsigned PH3_CYC = PH3_MS * (CLK_HZ / 1000);
	localparam int unsigned EXT_PROT_CYC = (EXT_PROT_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int unsigned OC_CLEAR_CYC = (OC_CLEAR_US * (CLK_HZ / 1000) + 999) / 1000;
	localparam int unsigned OLP_DELAY_CYC = OLP_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned RESTART_CYC = RESTART_MS * (CLK_HZ / 1000);
	localparam int unsigned TMR_W = 24;

	// Setup pin drive selection
	typedef enum logic [2:0] {
		LLCPS_PIN_CLAMP,
		LLCPS_PIN_SRC40,
		LLCPS_PIN_SRC10,
		LLCPS_PIN_SRC3,
		LLCPS_PIN_DISCH,
		LLCPS_PIN_OC_CHG,
		LLCPS_PIN_OC_DIS
	} llcps_pin_e;

	// Synchronised comparator outputs
	typedef struct packed {
		logic fb_start;      // feedback >= 0.7V
		logic fb_run;        // feedback >= 0.6V
		logic vcc_sel;       // supply reached 11V
		logic vcc_start;     // supply reached 14V
		logic mode_lim1;     // setup pin >= 2.65V
		logic mode_lim2;     // setup pin >= 3.15V
		logic mode_open;     // setup pin > 1.4V
		logic mode_high;     // setup pin >= 1.4V (oc oscillation)
		logic mode_low;      // setup pin <= 0.65V
		logic mode_ext;      // setup pin < 0.35V
		logic avg_up;        // power average >= 1.45V
		logic avg_dn;        // power average <= 0.6V
		logic avg_olp_lo;    // power average >= 1.5V
		logic avg_olp_hi;    // power average >= 3.0V
		logic oc_det;        // current sense overcurrent
	} llcps_cmp_s;

	typedef struct packed {
		logic sel_done;
		logic latch_off;
		logic [1:0] sel_phase;
		logic oc_stop;
		logic olp_stop;
		logic ext_stop;
	} llcps_stat_s;
endpackage : llcps_pkg

/* File: hw/llcps_sync.sv */
`timescale 1ns/1ps
module llcps_sync #(
	parameter int W = 15
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;

	if (W < 1) begin : g_bad_w
		$error("llcps_sync: W must be positive");
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_ff <= '0;
			s2_ff <= '0;
		end else begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
		end
	end

	assign q_o = s2_ff;
endmodule : llcps_sync

/* File: hw/llcps_timer.sv */
`timescale 1ns/1ps
module llcps_timer #(
	parameter int W = 24
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic run_i,
	input wire logic [W-1:0] limit_i,
	output logic done_o
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	if (W < 2) begin : g_bad_w
		$error("llcps_timer: W too small");
	end

	// Counts while run_i holds, saturates at limit, clears when run_i drops
	always_comb begin
		nxt_cnt = cnt_ff;
		if (!run_i) begin
			nxt_cnt = '0;
		end else if (cnt_ff < limit_i) begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign done_o = run_i && (cnt_ff >= limit_i);
endmodule : llcps_timer

/* File: hw/llcps_top.sv */
`timescale 1ns/1ps
module llcps_top
	import llcps_pkg::*;
#(
	parameter int unsigned PH1_CYCLES = PH1_CYC,
	parameter int unsigned PH2_CYCLES = PH2_CYC,
	parameter int unsigned PH3_CYCLES = PH3_CYC,
	parameter int unsigned OLP_CYCLES = OLP_DELAY_CYC,
	parameter int unsigned RESTART_CYCLES = RESTART_CYC,
	parameter int unsigned OC_OSC_MAX = OC_OSC_LIMIT
) (
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire llcps_pkg::llcps_cmp_s CMP_I,
	input wire logic STANDBY_SELECT_AUTO_I,
	output llcps_pkg::llcps_pin_e MODE_PIN_DRIVE_O,
	output logic [3:0] MODE_CODE_O,
	output logic MODE_VALID_O,
	output logic OLP_LEVEL_HI_O,
	output logic GAIN_LOW_O,
	output logic SWITCH_EN_O,
	output llcps_pkg::llcps_stat_s STATUS_O
);
	import llcps_pkg::*;

	if (PH1_CYCLES < 1 || PH2_CYCLES < 1 || PH3_CYCLES < 1 || OLP_CYCLES < 1
			|| RESTART_CYCLES < 1) begin : g_bad_zero
		$error("cycle counts must be positive");
	end
	if (PH1_CYCLES >= (1 << TMR_W) || PH2_CYCLES >= (1 << TMR_W) || PH3_CYCLES >= (1 << TMR_W)
			|| OLP_CYCLES >= (1 << TMR_W) || RESTART_CYCLES >= (1 << TMR_W)) begin : g_bad_wide
		$error("cycle counts exceed timer width");
	end
	if (OC_OSC_MAX < 1 || OC_OSC_MAX > 63) begin : g_bad_osc
		$error("OC_OSC_MAX out of range");
	end

	typedef enum {
		ST_WAIT_SEL, ST_PH1, ST_DIS1, ST_PH2, ST_DIS2, ST_PH3,
		ST_WAIT_VCC, ST_WAIT_FB, ST_RUN, ST_RESTART, ST_EXT, ST_LATCH
	} llcps_st_e;

	// ==========================================================
	// Comparator synchronisation
	llcps_cmp_s cmp;
	llcps_sync #(.W($bits(llcps_cmp_s))) u_sync (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.d_i(CMP_I),
		.q_o(cmp)
	);

	// ==========================================================
	// State registers
	llcps_st_e st_ff, nxt_st;
	logic [3:0] code_ff, nxt_code;
	logic valid_ff, nxt_valid;
	logic olp_hi_ff, nxt_olp_hi;
	logic gain_low_ff, nxt_gain_low;
	logic oc_phase_ff, nxt_oc_phase;
	logic [5:0] oc_cnt_ff, nxt_oc_cnt;
	logic [11:0] ext_cnt_ff, nxt_ext_cnt;
	logic [9:0] quiet_cnt_ff, nxt_quiet_cnt;
	logic oc_stop_ff, nxt_oc_stop;
	logic olp_stop_ff, nxt_olp_stop;

	// ==========================================================
	// Shared phase / delay timer
	logic tmr_run;
	logic [TMR_W-1:0] tmr_limit;
	logic tmr_done;
	logic olp_trip;
	logic olp_done;

	llcps_timer #(.W(TMR_W)) u_tmr (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.run_i(tmr_run),
		.limit_i(tmr_limit),
		.done_o(tmr_done)
	);

	llcps_timer #(.W(TMR_W)) u_olp (
		.clk_i(CLK_I),
		.nrst_i(NRST_I),
		.run_i(olp_trip && st_ff == ST_RUN),
		.limit_i(TMR_W'(OLP_CYCLES)),
		.done_o(olp_done)
	);

	always_comb begin
		tmr_run = 1'b0;
		tmr_limit = TMR_W'(PH1_CYCLES);
		case (st_ff)
			ST_PH1: begin
				tmr_run = 1'b1;
			end
			ST_PH2: begin
				tmr_run = 1'b1;
				tmr_limit = TMR_W'(PH2_CYCLES);
			end
			ST_PH3: begin
				tmr_run = 1'b1;
				tmr_limit = TMR_W'(PH3_CYCLES);
			end
			ST_RESTART: begin
				tmr_run = 1'b1;
				tmr_limit = TMR_W'(RESTART_CYCLES);
			end
			default: begin
				tmr_run = 1'b0;
			end
		endcase
	end

	// Overload level from standby selection
	assign olp_trip = olp_hi_ff ? cmp.avg_olp_hi : cmp.avg_olp_lo;

	// ==========================================================
	// Sequencer
	always_comb begin
		nxt_st = st_ff;
		nxt_code = code_ff;
		nxt_valid = valid_ff;
		nxt_olp_hi = olp_hi_ff;
		nxt_oc_stop = oc_stop_ff;
		nxt_olp_stop = olp_stop_ff;
		case (st_ff)
			ST_WAIT_SEL: begin
				if (cmp.vcc_sel) begin
					nxt_st = ST_PH1;
					nxt_olp_hi = STANDBY_SELECT_AUTO_I;
				end
			end
			ST_PH1: begin
				if (cmp.mode_lim1) begin
					nxt_st = ST_DIS1;
				end else if (tmr_done) begin
					nxt_code = 4'h0;
					nxt_st = ST_WAIT_VCC;
				end
			end
			ST_DIS1: begin
				if (!cmp.mode_low) begin
					nxt_st = ST_DIS1;
				end else begin
					nxt_st = ST_PH2;
				end
			end
			ST_PH2: begin
				if (cmp.mode_lim2) begin
					nxt_st = ST_DIS2;
				end else if (tmr_done) begin
					nxt_code = 4'h4;
					nxt_st = ST_WAIT_VCC;
				end
			end
			ST_DIS2: begin
				if (cmp.mode_low) begin
					nxt_st = ST_PH3;
				end
			end
			ST_PH3: begin
				if (cmp.mode_open) begin
					nxt_st = ST_LATCH;
				end else if (tmr_done) begin
					nxt_code = 4'h8;
					nxt_st = ST_WAIT_VCC;
				end
			end
			ST_WAIT_VCC: begin
				nxt_valid = 1'b1;
				if (cmp.vcc_start) begin
					nxt_st = ST_WAIT_FB;
				end
			end
			ST_WAIT_FB: begin
				if (cmp.mode_ext && ext_cnt_ff >= 12'(EXT_PROT_CYC)) begin
					nxt_st = ST_EXT;
				end else if (cmp.fb_start) begin
					nxt_st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (cmp.mode_ext && ext_cnt_ff >= 12'(EXT_PROT_CYC)) begin
					nxt_st = ST_EXT;
				end else if (oc_cnt_ff >= 6'(OC_OSC_MAX)) begin
					nxt_oc_stop = 1'b1;
					nxt_st = ST_RESTART;
				end else if (olp_done) begin
					nxt_olp_stop = 1'b1;
					nxt_st = ST_RESTART;
				end else if (!cmp.fb_run) begin
					nxt_st = ST_WAIT_FB;
				end
			end
			ST_RESTART: begin
				if (tmr_done) begin
					nxt_oc_stop = 1'b0;
					nxt_olp_stop = 1'b0;
					nxt_st = ST_WAIT_FB;
				end
			end
			ST_EXT: begin
				if (!cmp.mode_ext) begin
					nxt_st = ST_WAIT_FB;
				end
			end
			ST_LATCH: begin
				nxt_st = ST_LATCH;
			end
			default: begin
				nxt_st = ST_WAIT_SEL;
			end
		endcase
	end

	// ==========================================================
	// Overcurrent oscillation, external pull-down filter, gain
	always_comb begin
		nxt_oc_phase = oc_phase_ff;
		nxt_oc_cnt = oc_cnt_ff;
		nxt_quiet_cnt = quiet_cnt_ff;
		nxt_ext_cnt = ext_cnt_ff;
		nxt_gain_low = gain_low_ff;
		if (st_ff == ST_RUN && cmp.oc_det) begin
			nxt_quiet_cnt = '0;
		end else if (quiet_cnt_ff < 10'(OC_CLEAR_CYC)) begin
			nxt_quiet_cnt = quiet_cnt_ff + 10'h001;
		end
		if (st_ff != ST_RUN || quiet_cnt_ff >= 10'(OC_CLEAR_CYC)) begin
			nxt_oc_phase = 1'b0;
			nxt_oc_cnt = '0;
		end else if (!oc_phase_ff && (cmp.oc_det || oc_cnt_ff != '0) && cmp.mode_high) begin
			nxt_oc_phase = 1'b1;
		end else if (oc_phase_ff && cmp.mode_low) begin
			nxt_oc_phase = 1'b0;
			nxt_oc_cnt = oc_cnt_ff + 6'h01;
		end
		if (!cmp.mode_ext || !(st_ff == ST_RUN || st_ff == ST_WAIT_FB)) begin
			nxt_ext_cnt = '0;
		end else if (ext_cnt_ff < 12'(EXT_PROT_CYC)) begin
			nxt_ext_cnt = ext_cnt_ff + 12'h001;
		end
		if (!gain_low_ff && cmp.avg_up) begin
			nxt_gain_low = 1'b1;
		end else if (gain_low_ff && cmp.avg_dn) begin
			nxt_gain_low = 1'b0;
		end
	end

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_ff <= ST_WAIT_SEL;
			code_ff <= 4'h0;
			valid_ff <= 1'b0;
			olp_hi_ff <= 1'b0;
			gain_low_ff <= 1'b0;
			oc_phase_ff <= 1'b0;
			oc_cnt_ff <= 6'h00;
			ext_cnt_ff <= 12'h000;
			quiet_cnt_ff <= 10'h000;
			oc_stop_ff <= 1'b0;
			olp_stop_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			code_ff <= nxt_code;
			valid_ff <= nxt_valid;
			olp_hi_ff <= nxt_olp_hi;
			gain_low_ff <= nxt_gain_low;
			oc_phase_ff <= nxt_oc_phase;
			oc_cnt_ff <= nxt_oc_cnt;
			ext_cnt_ff <= nxt_ext_cnt;
			quiet_cnt_ff <= nxt_quiet_cnt;
			oc_stop_ff <= nxt_oc_stop;
			olp_stop_ff <= nxt_olp_stop;
		end
	end

	// ==========================================================
	// Outputs
	always_comb begin
		case (st_ff)
			ST_PH1: MODE_PIN_DRIVE_O = LLCPS_PIN_SRC40;
			ST_PH2: MODE_PIN_DRIVE_O = LLCPS_PIN_SRC10;
			ST_PH3: MODE_PIN_DRIVE_O = LLCPS_PIN_SRC3;
			ST_DIS1, ST_DIS2: MODE_PIN_DRIVE_O = LLCPS_PIN_DISCH;
			ST_RUN: begin
				if (oc_phase_ff) begin
					MODE_PIN_DRIVE_O = LLCPS_PIN_OC_DIS;
				end else if (cmp.oc_det || oc_cnt_ff != '0) begin
					MODE_PIN_DRIVE_O = LLCPS_PIN_OC_CHG;
				end else begin
					MODE_PIN_DRIVE_O = LLCPS_PIN_CLAMP;
				end
			end
			default: MODE_PIN_DRIVE_O = LLCPS_PIN_CLAMP;
		endcase
	end

	assign MODE_CODE_O = code_ff;
	assign MODE_VALID_O = valid_ff && olp_hi_ff;
	assign OLP_LEVEL_HI_O = olp_hi_ff;
	assign GAIN_LOW_O = gain_low_ff;
	assign SWITCH_EN_O = (st_ff == ST_RUN);
	assign STATUS_O.sel_done = valid_ff;
	assign STATUS_O.latch_off = (st_ff == ST_LATCH);
	assign STATUS_O.sel_phase = (st_ff == ST_PH1) ? 2'h1 :
		((st_ff == ST_PH2) ? 2'h2 : ((st_ff == ST_PH3) ? 2'h3 : 2'h0));
	assign STATUS_O.oc_stop = oc_stop_ff;
	assign STATUS_O.olp_stop = olp_stop_ff;
	assign STATUS_O.ext_stop = (st_ff == ST_EXT);
endmodule : llcps_top

/* File: verif/llcps_top_monitor.sv */
`timescale 1ns/1ps
// ========
// Port checker
module llcps_top_monitor
	import llcps_pkg::*;
(
	input wire logic CLK_I,
	input wire logic NRST_I,
	input wire llcps_pkg::llcps_cmp_s CMP_I,
	input wire logic STANDBY_SELECT_AUTO_I,
	input wire llcps_pkg::llcps_pin_e MODE_PIN_DRIVE_O,
	input wire logic [3:0] MODE_CODE_O,
	input wire logic MODE_VALID_O,
	input wire logic OLP_LEVEL_HI_O,
	input wire logic GAIN_LOW_O,
	input wire logic SWITCH_EN_O,
	input wire llcps_pkg::llcps_stat_s STATUS_O
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!NRST_I);
	sequence s_fb_low;
		!CMP_I.fb_run [*5];
	endsequence
	property p_start;
		$rose(SWITCH_EN_O) |-> $past(CMP_I.fb_start, 2) || $past(CMP_I.fb_start, 3)
			|| $past(CMP_I.fb_start, 4);
	endproperty
	property p_stop;
		s_fb_low |-> !SWITCH_EN_O;
	endproperty
	property p_phase;
		(MODE_PIN_DRIVE_O == LLCPS_PIN_SRC40 |-> STATUS_O.sel_phase == 2'h1)
			and (MODE_PIN_DRIVE_O == LLCPS_PIN_SRC10 |-> STATUS_O.sel_phase == 2'h2)
			and (MODE_PIN_DRIVE_O == LLCPS_PIN_SRC3 |-> STATUS_O.sel_phase == 2'h3);
	endproperty
	property p_latch;
		STATUS_O.latch_off |=> STATUS_O.latch_off && !SWITCH_EN_O;
	endproperty
	property p_clamp;
		STATUS_O.sel_done && !SWITCH_EN_O && !STATUS_O.latch_off
			|-> MODE_PIN_DRIVE_O == LLCPS_PIN_CLAMP;
	endproperty
	property p_gain_up;
		$rose(GAIN_LOW_O) |-> $past(CMP_I.avg_up, 2) || $past(CMP_I.avg_up, 3)
			|| $past(CMP_I.avg_up, 4);
	endproperty
	property p_gain_dn;
		$fell(GAIN_LOW_O) |-> $past(CMP_I.avg_dn, 2) || $past(CMP_I.avg_dn, 3)
			|| $past(CMP_I.avg_dn, 4);
	endproperty
	property p_valid;
		MODE_VALID_O |-> STATUS_O.sel_done && OLP_LEVEL_HI_O;
	endproperty
	property p_en_sel;
		SWITCH_EN_O |-> STATUS_O.sel_done && !STATUS_O.latch_off;
	endproperty
	a_start: assert property (p_start) else $error("switching began without start level");
	a_stop: assert property (p_stop) else $error("switching kept below run level");
	a_phase: assert property (p_phase)
		else $error("source current in wrong phase");
	a_latch: assert property (p_latch) else $error("latch off released");
	a_clamp: assert property (p_clamp) else $error("setup pin not clamped");
	a_gain_up: assert property (p_gain_up) else $error("gain raised without cause");
	a_gain_dn: assert property (p_gain_dn) else $error("gain lowered without cause");
	a_valid: assert property (p_valid)
		else $error("modes valid outside auto standby");
	a_en_sel: assert property (p_en_sel) else $error("switching before selection end");
endmodule : llcps_top_monitor

bind llcps_top llcps_top_monitor i_mon (.CLK_I, .NRST_I, .CMP_I, .STANDBY_SELECT_AUTO_I,
	.MODE_PIN_DRIVE_O, .MODE_CODE_O, .MODE_VALID_O, .OLP_LEVEL_HI_O, .GAIN_LOW_O,
	.SWITCH_EN_O, .STATUS_O);

/* File: verif/llcps_analog_model.sv */
`timescale 1ns/1ps
// ========
// Setup pin network with its comparators, voltage in mV
module llcps_analog_model
	import llcps_pkg::*;
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire llcps_pkg::llcps_pin_e drive_i,
	input wire logic [15:0] res_k_i,
	input wire logic ext_pull_i,
	output llcps_pkg::llcps_cmp_s cmp_o,
	output logic [7:0] osc_o
);
	int v;
	llcps_pin_e prv;
	function automatic int step(input int a, input int t);
		return (a + 100 > t) ? t : a + 100;
	endfunction : step
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			v <= 0;
			osc_o <= 8'h00;
			prv <= LLCPS_PIN_CLAMP;
		end else begin
			prv <= drive_i;
			if (prv == LLCPS_PIN_OC_DIS && drive_i != LLCPS_PIN_OC_DIS) begin
				osc_o <= osc_o + 8'h01;
			end
			case (drive_i)
				LLCPS_PIN_SRC40: v <= step(v, 40 * res_k_i);
				LLCPS_PIN_SRC10: v <= step(v, 10 * res_k_i);
				LLCPS_PIN_SRC3: v <= step(v, 3 * res_k_i);
				LLCPS_PIN_DISCH: v <= (v > 500) ? v - 500 : 0;
				LLCPS_PIN_OC_CHG: v <= v + 50;
				LLCPS_PIN_OC_DIS: v <= (v > 50) ? v - 50 : 0;
				default: v <= ext_pull_i ? 100 : 530;
			endcase
		end
	end
	always_comb begin
		cmp_o = '0;
		cmp_o.mode_lim1 = (v >= 2650);
		cmp_o.mode_lim2 = (v >= 3150);
		cmp_o.mode_open = (v > 1400);
		cmp_o.mode_high = (v >= 1400);
		cmp_o.mode_low = (v <= 650);
		cmp_o.mode_ext = (v < 350);
	end
endmodule : llcps_analog_model

/* File: verif/test_llcps_top.sv */
`timescale 1ns/1ps
// ========
// Sequencer tests
module test_llcps_top;
	import llcps_pkg::*;
	localparam int PH = 50;
	localparam int OVERLOAD_PROTECTION = 60;
	localparam int RST = 80;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic auto_sel = 1'b1;
	logic ext_pull = 1'b0;
	logic [15:0] res_k = 16'h001E;
	llcps_cmp_s cmp = '0;
	llcps_cmp_s pin_cmp;
	llcps_cmp_s cmp_all;
	llcps_pin_e drive;
	logic [3:0] code;
	logic valid;
	logic olp_hi;
	logic gain;
	logic en;
	llcps_stat_s stat;
	logic [7:0] osc;
	int err_total = 0;
	int n_compared = 0;
	assign cmp_all = cmp | pin_cmp;
	always #50 clk = ~clk;
	llcps_top #(.PH1_CYCLES(PH), .PH2_CYCLES(PH), .PH3_CYCLES(PH), .OLP_CYCLES(OVERLOAD_PROTECTION),
		.RESTART_CYCLES(RST)) i_dut (.CLK_I(clk), .NRST_I(nrst), .CMP_I(cmp_all),
		.STANDBY_SELECT_AUTO_I(auto_sel), .MODE_PIN_DRIVE_O(drive), .MODE_CODE_O(code),
		.MODE_VALID_O(valid), .OLP_LEVEL_HI_O(olp_hi), .GAIN_LOW_O(gain),
		.SWITCH_EN_O(en), .STATUS_O(stat));
	llcps_analog_model i_pin (.clk_i(clk), .nrst_i(nrst), .drive_i(drive), .res_k_i(res_k),
		.ext_pull_i(ext_pull), .cmp_o(pin_cmp), .osc_o(osc));
	// ========
	// Shared tasks; checks run at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic report;
		err_total++;
		$display("Error at %0t: output mismatch", $time);
	endtask : report
	task automatic chk(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) report();
	endtask : chk
	task automatic chk_code(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp) report();
	endtask : chk_code
	function automatic logic sig(input int w);
		case (w)
			0: return en;
			1: return stat.sel_done;
			2: return stat.oc_stop;
			default: return stat.latch_off;
		endcase
	endfunction : sig
	task automatic wt(input int w, input logic e, input int lim);
		int k;
		k = 0;
		while (sig(w) !== e && k < lim) begin
			cyc(1);
			k++;
		end
		chk(sig(w), e);
	endtask : wt
	task automatic power_up(input logic auto_v, input logic [15:0] res_v);
		@(posedge clk);
		nrst <= 1'b0;
		auto_sel <= auto_v;
		res_k <= res_v;
		cmp <= '0;
		ext_pull <= 1'b0;
		cyc(10);
		@(posedge clk);
		nrst <= 1'b1;
		cyc(3);
		@(posedge clk);
		cmp.vcc_sel <= 1'b1;
	endtask : power_up
	task automatic test_done;
		$display("Compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (20000) @(posedge clk);
		report();
		test_done();
	end
	// ========
	// Main sequence
	initial begin
		cyc(10);
		@(posedge clk);
		nrst <= 1'b1;
		cyc(3);
		chk(en, 1'b0);
		chk(drive === LLCPS_PIN_CLAMP, 1'b1);
		@(posedge clk);
		cmp.vcc_sel <= 1'b1;
		cyc(5);
		chk(drive === LLCPS_PIN_SRC40, 1'b1);
		cyc(PH - 12);
		chk(stat.sel_done, 1'b0);
		wt(1, 1'b1, 40);
		chk_code(code, 4'h0);
		chk(valid, 1'b1);
		chk(olp_hi, 1'b1);
		@(posedge clk);
		cmp.fb_start <= 1'b1;
		cmp.fb_run <= 1'b1;
		cyc(20);
		chk(en, 1'b0);
		@(posedge clk);
		cmp.fb_start <= 1'b0;
		cmp.fb_run <= 1'b0;
		cmp.vcc_start <= 1'b1;
		cyc(10);
		chk(en, 1'b0);
		@(posedge clk);
		cmp.fb_run <= 1'b1;
		cyc(10);
		chk(en, 1'b0);
		@(posedge clk);
		cmp.fb_start <= 1'b1;
		wt(0, 1'b1, 10);
		@(posedge clk);
		cmp.fb_start <= 1'b0;
		cyc(10);
		chk(en, 1'b1);
		@(posedge clk);
		cmp.fb_run <= 1'b0;
		wt(0, 1'b0, 10);
		@(posedge clk);
		cmp.fb_run <= 1'b1;
		cmp.fb_start <= 1'b1;
		cmp.avg_up <= 1'b1;
		cyc(5);
		chk(gain, 1'b1);
		@(posedge clk);
		cmp.avg_up <= 1'b0;
		cmp.avg_dn <= 1'b1;
		cyc(5);
		chk(gain, 1'b0);
		@(posedge clk);
		cmp.avg_dn <= 1'b0;
		ext_pull <= 1'b1;
		cyc(3000);
		chk(en, 1'b1);
		wt(0, 1'b0, 100);
		chk(stat.ext_stop, 1'b1);
		@(posedge clk);
		ext_pull <= 1'b0;
		wt(0, 1'b1, 20);
		@(posedge clk);
		cmp.oc_det <= 1'b1;
		wt(2, 1'b1, 2500);
		chk(osc === 8'h20, 1'b1);
		chk(en, 1'b0);
		@(posedge clk);
		cmp.oc_det <= 1'b0;
		cyc(RST - 10);
		chk(en, 1'b0);
		wt(0, 1'b1, 40);
		@(posedge clk);
		cmp.oc_det <= 1'b1;
		cyc(100);
		@(posedge clk);
		cmp.oc_det <= 1'b0;
		cyc(OC_CLEAR_CYC + 100);
		chk(drive === LLCPS_PIN_CLAMP, 1'b1);
		chk(en, 1'b1);
		@(posedge clk);
		cmp.avg_olp_lo <= 1'b1;
		cyc(OVERLOAD_PROTECTION + 20);
		chk(en, 1'b1);
		@(posedge clk);
		cmp.avg_olp_hi <= 1'b1;
		cyc(OVERLOAD_PROTECTION - 10);
		chk(en, 1'b1);
		wt(0, 1'b0, 30);
		chk(stat.olp_stop, 1'b1);
		@(posedge clk);
		cmp.avg_olp_lo <= 1'b0;
		cmp.avg_olp_hi <= 1'b0;
		cyc(RST - 10);
		chk(en, 1'b0);
		wt(0, 1'b1, 40);
		power_up(1'b0, 16'h2710);
		wt(3, 1'b1, 3 * PH + 100);
		chk(valid, 1'b0);
		chk(olp_hi, 1'b0);
		@(posedge clk);
		cmp.vcc_start <= 1'b1;
		cmp.fb_start <= 1'b1;
		cmp.fb_run <= 1'b1;
		cyc(20);
		chk(en, 1'b0);
		chk(stat.latch_off, 1'b1);
		power_up(1'b0, 16'h0190);
		wt(1, 1'b1, 3 * PH + 100);
		chk_code(code, 4'h8);
		chk(valid, 1'b0);
		chk(olp_hi, 1'b0);
		@(posedge clk);
		cmp.vcc_start <= 1'b1;
		cmp.fb_start <= 1'b1;
		cmp.fb_run <= 1'b1;
		wt(0, 1'b1, 20);
		@(posedge clk);
		cmp.avg_olp_lo <= 1'b1;
		wt(0, 1'b0, OVERLOAD_PROTECTION + 20);
		chk(stat.olp_stop, 1'b1);
		power_up(1'b1, 16'h0064);
		wt(1, 1'b1, 2 * PH + 60);
		chk_code(code, 4'h4);
		chk(valid, 1'b1);
		test_done();
	end
endmodule : test_llcps_top
